/* verilog/fte_regs.svh */
`ifndef FTE_REGS_SVH
`define FTE_REGS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define FTE_ADDR_CONFIG 8'h03
`define FTE_ADDR_SCRATCH_A 8'h0d
`define FTE_ADDR_SCRATCH_B 8'h0e
`define FTE_ADDR_SCRATCH_C 8'h0f

// ----------------------------------------------------------------
// Event configuration fields
// ----------------------------------------------------------------
`define FTE_BIT_SIGNED 24
`define FTE_BIT_DELTA 23
`define FTE_BIT_NV_STATUS 22
`define FTE_BIT_NV_ENABLE 21
`define FTE_BIT_EN_Z 20
`define FTE_BIT_EN_Y 19
`define FTE_BIT_EN_X 18
`define FTE_THR_W 6
`define FTE_CFG_USED 25
`define FTE_SCRATCH_W 26
`define FTE_RESET_WORD 32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FTE_CLK_NS 100
`define FTE_NV_WRITE_US 10
`define FTE_NV_WRITE_CYC ((`FTE_NV_WRITE_US * 1000) / `FTE_CLK_NS)

`endif

/* verilog/fte_pkg.sv */
package fte_pkg;
    // Persistent status write sequencer
    typedef enum logic [1:0] {
        FTE_NV_IDLE,
        FTE_NV_BUSY
    } fte_nv_state_t;
endpackage : fte_pkg

/* verilog/fte_axis_cmp.sv */
`include "fte_regs.svh"

// Per-axis threshold comparison, one instance per axis
module fte_axis_cmp #(
    parameter int SAMPLE_W = 12
) (
    // Inputs
    input wire logic signed [SAMPLE_W-1:0] sample,
    input wire logic signed [SAMPLE_W-1:0] reference,
    input wire logic [`FTE_THR_W-1:0] threshold,
    input wire logic enable,
    input wire logic signed_mode,
    input wire logic delta_mode,
    // Result
    output logic hit
);
    // ----------------------------------------------------------------
    // Compare
    // ----------------------------------------------------------------
    logic signed [SAMPLE_W:0] diff; // One extra bit keeps delta exact
    logic signed [SAMPLE_W:0] thr_s; // Threshold as signed value
    logic [SAMPLE_W:0] mag; // Absolute magnitude of diff
    logic [SAMPLE_W:0] thr_u; // Threshold as magnitude

    // Threshold is 6 bits wide; signed view is two's complement
    always_comb begin
        if (delta_mode) begin
            diff = sample - reference;
        end else begin
            diff = {sample[SAMPLE_W-1], sample};
        end
        thr_u = {{(SAMPLE_W+1-`FTE_THR_W){1'b0}}, threshold};
        thr_s = {{(SAMPLE_W+1-`FTE_THR_W){threshold[`FTE_THR_W-1]}},
                 threshold};
        mag = diff[SAMPLE_W] ? -diff : diff;
        if (!enable) begin
            hit = 1'b0;
        end else if (signed_mode) begin
            // Sign of threshold picks the direction
            if (thr_s < 0) begin
                hit = diff <= thr_s;
            end else begin
                hit = diff >= thr_s;
            end
        end else begin
            hit = mag >= thr_u; // Either direction
        end
    end
endmodule : fte_axis_cmp

/* verilog/fte_event_core.sv */
`include "fte_regs.svh"

module fte_event_core #(
    parameter int SAMPLE_W = 12,
    parameter int NV_WRITE_CYC = `FTE_NV_WRITE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_wr_ok,
    // Mode controls
    input wire logic access_enabled,
    input wire logic latch_enable,
    input wire logic event_clear,
    input wire logic duty_cycle_pin,
    // Measurement
    input wire logic sample_valid,
    input wire logic [3*SAMPLE_W-1:0] sample_xyz,
    // Status
    output logic event_out_n,
    output logic event_status,
    output logic nv_write_busy
);
    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // Elaboration stops on sizes the datapath cannot hold
    if (SAMPLE_W <= `FTE_THR_W || SAMPLE_W > 16) begin : g_bad_sample_w
        $error("fte_event_core: SAMPLE_W out of range");
    end
    if (NV_WRITE_CYC < 1 || NV_WRITE_CYC > 65535) begin : g_bad_nv_cyc
        $error("fte_event_core: NV_WRITE_CYC out of range");
    end

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [`FTE_CFG_USED-1:0] cfg_reg; // Event configuration word
    logic [`FTE_SCRATCH_W-1:0] scratch_reg [3]; // User scratch words
    logic [3*SAMPLE_W-1:0] ref_reg; // Delta reference sample
    logic ref_valid_reg; // Reference captured this visit
    logic duty_meta_reg; // Synchroniser first stage
    logic duty_sync_reg; // Synchroniser second stage
    logic hit_reg; // Current event level
    logic status_reg; // Volatile event status
    logic out_n_reg; // Event output, active low
    logic [1:0] sel_idx; // Scratch index from address
    logic sel_scratch; // Address hits a scratch word
    logic wr_cfg; // Host write to configuration
    logic nv_set; // Hardware persistent status set
    logic [2:0] axis_hit; // Per-axis comparator results
    logic any_hit; // Combined event
    logic event_rise; // New event occurrence
    fte_pkg::fte_nv_state_t nv_state_reg;
    logic [15:0] nv_cnt_reg; // Persistent write timer

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    always_comb begin
        sel_scratch = 1'b0;
        sel_idx = 2'h0;
        if (reg_addr == `FTE_ADDR_SCRATCH_A) begin
            sel_scratch = 1'b1;
            sel_idx = 2'h0;
        end else if (reg_addr == `FTE_ADDR_SCRATCH_B) begin
            sel_scratch = 1'b1;
            sel_idx = 2'h1;
        end else if (reg_addr == `FTE_ADDR_SCRATCH_C) begin
            sel_scratch = 1'b1;
            sel_idx = 2'h2;
        end
    end

    // Writes only land in access mode
    assign wr_cfg = reg_wr && access_enabled
                    && reg_addr == `FTE_ADDR_CONFIG;

    // ----------------------------------------------------------------
    // Read data and write acknowledge
    // ----------------------------------------------------------------
    // Reads never need access mode; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= `FTE_RESET_WORD;
        end else if (reg_addr == `FTE_ADDR_CONFIG) begin
            reg_rdata <= {{(32-`FTE_CFG_USED){1'b0}}, cfg_reg};
        end else if (sel_scratch) begin
            reg_rdata <= {{(32-`FTE_SCRATCH_W){1'b0}},
                          scratch_reg[sel_idx]};
        end else begin
            reg_rdata <= `FTE_RESET_WORD;
        end
    end

    // Pulse tells the host a write was accepted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_wr_ok <= 1'b0;
        end else begin
            reg_wr_ok <= reg_wr && access_enabled
                         && (sel_scratch
                             || reg_addr == `FTE_ADDR_CONFIG);
        end
    end

    // ----------------------------------------------------------------
    // Configuration word
    // ----------------------------------------------------------------
    // Reset stands in for the factory default of the stored word.
    // Hardware set of the persistent flag wins over a host write.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_reg <= `FTE_CFG_USED'(`FTE_RESET_WORD);
        end else begin
            if (wr_cfg) begin
                cfg_reg <= reg_wdata[`FTE_CFG_USED-1:0];
            end
            if (nv_set) begin
                cfg_reg[`FTE_BIT_NV_STATUS] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Scratch words, stored only, read by nothing but the register read path
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_scratch
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    scratch_reg[gi] <= `FTE_SCRATCH_W'h0;
                end else if (reg_wr && access_enabled && sel_scratch
                             && sel_idx == 2'(gi)) begin
                    scratch_reg[gi] <=
                        reg_wdata[`FTE_SCRATCH_W-1:0];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Duty-cycle mode synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            duty_meta_reg <= 1'b0;
            duty_sync_reg <= 1'b0;
        end else begin
            duty_meta_reg <= duty_cycle_pin;
            duty_sync_reg <= duty_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Delta reference capture
    // ----------------------------------------------------------------
    // First sample after entering duty cycle becomes the reference;
    // leaving the mode re-arms the capture for the next entry.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_reg <= '0;
            ref_valid_reg <= 1'b0;
        end else if (!duty_sync_reg) begin
            ref_valid_reg <= 1'b0;
        end else if (sample_valid && !ref_valid_reg) begin
            ref_reg <= sample_xyz;
            ref_valid_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Per-axis comparators
    // ----------------------------------------------------------------
    generate
        for (gi = 0; gi < 3; gi++) begin : g_axis
            fte_axis_cmp #(
                .SAMPLE_W(SAMPLE_W)
            ) u_cmp (
                .sample(sample_xyz[gi*SAMPLE_W +: SAMPLE_W]),
                .reference(ref_reg[gi*SAMPLE_W +: SAMPLE_W]),
                .threshold(cfg_reg[gi*`FTE_THR_W +: `FTE_THR_W]),
                .enable(cfg_reg[`FTE_BIT_EN_X + gi]),
                .signed_mode(cfg_reg[`FTE_BIT_SIGNED]),
                .delta_mode(cfg_reg[`FTE_BIT_DELTA]),
                .hit(axis_hit[gi])
            );
        end
    endgenerate

    // Delta comparisons need a reference in duty-cycle mode
    assign any_hit = (|axis_hit) && (!cfg_reg[`FTE_BIT_DELTA]
                     || (duty_sync_reg && ref_valid_reg));

    // ----------------------------------------------------------------
    // Event level, evaluated on each new measurement
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hit_reg <= 1'b0;
        end else if (sample_valid) begin
            hit_reg <= any_hit;
        end
    end

    assign event_rise = sample_valid && any_hit && !hit_reg;

    // ----------------------------------------------------------------
    // Volatile status and output
    // ----------------------------------------------------------------
    // Latched: held until cleared; a new event beats the clear.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <= 1'b0;
        end else if (latch_enable) begin
            if (sample_valid && any_hit) begin
                status_reg <= 1'b1;
            end else if (event_clear) begin
                status_reg <= 1'b0;
            end
        end else if (sample_valid) begin
            status_reg <= any_hit; // Follows the condition
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_n_reg <= 1'b1;
        end else begin
            out_n_reg <= !status_reg;
        end
    end

    assign event_out_n = out_n_reg;
    assign event_status = status_reg;

    // ----------------------------------------------------------------
    // Persistent status write sequencer
    // ----------------------------------------------------------------
    // Models the store's write time; the flag sets at the end.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_state_reg <= fte_pkg::FTE_NV_IDLE;
            nv_cnt_reg <= 16'h0;
        end else begin
            case (nv_state_reg)
                fte_pkg::FTE_NV_IDLE: begin
                    if (event_rise && cfg_reg[`FTE_BIT_NV_ENABLE]) begin
                        nv_state_reg <= fte_pkg::FTE_NV_BUSY;
                        nv_cnt_reg <= 16'(NV_WRITE_CYC - 1);
                    end
                end
                fte_pkg::FTE_NV_BUSY: begin
                    if (nv_cnt_reg == 16'h0) begin
                        nv_state_reg <= fte_pkg::FTE_NV_IDLE;
                    end else begin
                        nv_cnt_reg <= nv_cnt_reg - 16'h1;
                    end
                end
                default: begin
                    nv_state_reg <= fte_pkg::FTE_NV_IDLE;
                end
            endcase
        end
    end

    assign nv_set = nv_state_reg == fte_pkg::FTE_NV_BUSY
                    && nv_cnt_reg == 16'h0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nv_write_busy <= 1'b0;
        end else begin
            nv_write_busy <= (nv_state_reg == fte_pkg::FTE_NV_IDLE)
                ? (event_rise && cfg_reg[`FTE_BIT_NV_ENABLE])
                : !nv_set;
        end
    end
endmodule : fte_event_core

/* bench/fte_sva_chk_sva.sv */
module fte_sva_chk #(
    parameter int SAMPLE_W = 12,
    parameter int NV_WRITE_CYC = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_wr_ok,
    // Mode controls
    input wire logic access_enabled,
    input wire logic latch_enable,
    input wire logic event_clear,
    input wire logic duty_cycle_pin,
    // Measurement and status
    input wire logic sample_valid,
    input wire logic [3*SAMPLE_W-1:0] sample_xyz,
    input wire logic event_out_n,
    input wire logic event_status,
    input wire logic nv_write_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // --------------------------------------------------------
    // Helper logic
    // --------------------------------------------------------
    int busy_cnt; // Cycles of the current persistent write
    logic mapped; // Address hits a stored word
    logic take; // A write that must be accepted
    assign mapped = reg_addr == 8'h03 || reg_addr == 8'h0d ||
                    reg_addr == 8'h0e || reg_addr == 8'h0f;
    assign take = reg_wr && access_enabled && mapped;
    // Counts busy cycles; cleared in reset so a cut write is forgotten
    always_ff @(posedge clk) begin
        busy_cnt <= (rst_n && nv_write_busy) ? busy_cnt + 1 : 0;
    end
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    property p_wr_ok;
        take |=> reg_wr_ok;
    endproperty
    property p_wr_cause;
        reg_wr_ok |-> $past(take);
    endproperty
    property p_rsvd;
        reg_rdata[31:26] == 6'h00 &&
        ($past(reg_addr) != 8'h03 || !reg_rdata[25]);
    endproperty
    property p_out;
        event_out_n == !$past(event_status);
    endproperty
    property p_st_rise;
        $rose(event_status) |-> $past(sample_valid);
    endproperty
    property p_hold;
        !latch_enable && !sample_valid && !event_clear
            |=> $stable(event_status);
    endproperty
    property p_latch;
        latch_enable && event_status && !event_clear |=> event_status;
    endproperty
    property p_clear;
        latch_enable && event_clear && !sample_valid |=> !event_status;
    endproperty
    property p_busy_len;
        $fell(nv_write_busy) |-> busy_cnt == NV_WRITE_CYC;
    endproperty
    property p_busy_rise;
        $rose(nv_write_busy) |-> event_status;
    endproperty
    a_wr_ok: assert property (p_wr_ok)
        else $error("accepted write gave no ok pulse");
    a_wr_cause: assert property (p_wr_cause)
        else $error("ok pulse without an allowed write");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved read bits not zero");
    a_out: assert property (p_out)
        else $error("event output does not follow status");
    a_st_rise: assert property (p_st_rise)
        else $error("status rose without a sample");
    a_hold: assert property (p_hold)
        else $error("unlatched status moved between samples");
    a_latch: assert property (p_latch)
        else $error("latched status dropped");
    a_clear: assert property (p_clear)
        else $error("clear did not drop latched status");
    a_busy_len: assert property (p_busy_len)
        else $error("persistent write length wrong");
    a_busy_rise: assert property (p_busy_rise)
        else $error("persistent write without an event");
    c_event: cover property ($rose(event_status));
    c_busy: cover property ($fell(nv_write_busy));
    c_clear: cover property (latch_enable && event_clear && event_status);
endmodule : fte_sva_chk

bind fte_event_core fte_sva_chk #(.SAMPLE_W(SAMPLE_W),
    .NV_WRITE_CYC(NV_WRITE_CYC)) u_fte_sva_chk (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_wr_ok(reg_wr_ok),
    .access_enabled(access_enabled), .latch_enable(latch_enable),
    .event_clear(event_clear), .duty_cycle_pin(duty_cycle_pin),
    .sample_valid(sample_valid), .sample_xyz(sample_xyz),
    .event_out_n(event_out_n), .event_status(event_status),
    .nv_write_busy(nv_write_busy));

/* bench/fte_host_model.sv */
module fte_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    output logic access_enabled,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_wr_ok
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle host: no write, access mode off
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 32'h0000_0000;
        access_enabled = 1'b0;
    end
    // Enters or leaves the access mode that gates writes
    task automatic acc(input logic on);
        @(posedge clk);
        access_enabled <= on;
    endtask : acc
    // One write; ok catches the pulse in either following cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic ok);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // Released data must not look valid
        #1 ok = reg_wr_ok;
        @(posedge clk);
        #1 ok = ok | reg_wr_ok;
    endtask : wr
    // Reads need no access mode, so none is asked for here
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 d = reg_rdata;
    endtask : rd
endmodule : fte_host_model

/* bench/fte_event_core_tb_top.sv */
module fte_event_core_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NVC = 4; // Short persistent write for simulation
    // --------------------------------------------------------
    // Signals
    // --------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr;
    logic reg_wr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_wr_ok;
    logic access_enabled;
    logic latch_enable = 1'b0;
    logic event_clear = 1'b0;
    logic duty_cycle_pin = 1'b0;
    logic sample_valid = 1'b0;
    logic [35:0] sample_xyz = 36'h0;
    logic event_out_n;
    logic event_status;
    logic nv_write_busy;
    int err_count = 0;
    int comparisons = 0;
    int n;
    logic [7:0] ad [4] = '{8'h03, 8'h0d, 8'h0e, 8'h0f};
    logic [31:0] rv;
    logic ok;
    always #50 clk = ~clk;
    // --------------------------------------------------------
    // Instances
    // --------------------------------------------------------
    fte_event_core #(.SAMPLE_W(12), .NV_WRITE_CYC(NVC)) u_fte_event_core (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_wr_ok(reg_wr_ok), .access_enabled(access_enabled),
        .latch_enable(latch_enable), .event_clear(event_clear),
        .duty_cycle_pin(duty_cycle_pin), .sample_valid(sample_valid),
        .sample_xyz(sample_xyz), .event_out_n(event_out_n),
        .event_status(event_status), .nv_write_busy(nv_write_busy));
    fte_host_model u_fte_host_model (.clk(clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .access_enabled(access_enabled), .reg_rdata(reg_rdata),
        .reg_wr_ok(reg_wr_ok));
    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic w(input logic [7:0] a, input logic [31:0] d,
                     input logic eok);
        u_fte_host_model.wr(a, d, ok);
        chk("reg_wr_ok", {31'h0, eok}, {31'h0, ok});
    endtask : w
    task automatic r(input logic [7:0] a, input logic [31:0] exp);
        u_fte_host_model.rd(a, rv);
        chk("reg_rdata", exp, rv);
    endtask : r
    // One measurement; status after one edge, output after two
    task automatic smp(input logic [11:0] x, y, z, input logic hit);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_xyz <= {z, y, x};
        @(posedge clk);
        sample_valid <= 1'b0;
        #1 chk("event_status", {31'h0, hit}, {31'h0, event_status});
        @(posedge clk);
        #1 chk("event_out_n", {31'h0, !hit}, {31'h0, event_out_n});
    endtask : smp
    task automatic wrap_up;
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ad[i]) r(ad[i], 32'h0);
        w(8'h0d, 32'hffff_ffff, 1'b0);
        r(8'h0d, 32'h0);
        u_fte_host_model.acc(1'b1);
        // Write every scratch word before reading any, to catch aliasing
        for (int i = 1; i < 4; i++) begin
            w(ad[i], 32'hffff_fff0 | i, 1'b1);
        end
        w(8'h05, 32'hffff_ffff, 1'b0);
        for (int i = 1; i < 4; i++) r(ad[i], 32'h03ff_fff0 | i);
        r(8'h05, 32'h0);
        // Absolute, X only; Z threshold set but Z gated off
        w(8'h03, 32'hfe04_c00a, 1'b1);
        r(8'h03, 32'h0004_c00a);
        smp(12'hff4, 12'h0, 12'h0, 1'b1);
        smp(12'h005, 12'h0, 12'h064, 1'b0);
        smp(12'h00a, 12'h0, 12'h0, 1'b1);
        smp(12'h009, 12'h0, 12'h0, 1'b0);
        // All axes enabled, results combined
        w(8'h03, 32'h001c_c50a, 1'b1);
        smp(12'h0, 12'hfec, 12'h0, 1'b1);
        smp(12'h0, 12'h0, 12'h00c, 1'b1);
        smp(12'h009, 12'h013, 12'h00b, 1'b0);
        // Signed thresholds, positive then negative
        w(8'h03, 32'h0104_000a, 1'b1);
        smp(12'hff4, 12'h0, 12'h0, 1'b0);
        smp(12'h00c, 12'h0, 12'h0, 1'b1);
        w(8'h03, 32'h0104_0036, 1'b1);
        smp(12'h00c, 12'h0, 12'h0, 1'b0);
        smp(12'hff4, 12'h0, 12'h0, 1'b1);
        // Latched status survives a quiet sample until cleared
        w(8'h03, 32'h0004_000a, 1'b1);
        @(posedge clk);
        latch_enable <= 1'b1;
        smp(12'h00c, 12'h0, 12'h0, 1'b1);
        smp(12'h0, 12'h0, 12'h0, 1'b1);
        @(posedge clk);
        event_clear <= 1'b1;
        @(posedge clk);
        event_clear <= 1'b0;
        #1 chk("event_status", 32'h0, {31'h0, event_status});
        @(posedge clk);
        latch_enable <= 1'b0;
        // Event with persistent record enabled
        w(8'h03, 32'h0024_000a, 1'b1);
        smp(12'h00c, 12'h0, 12'h0, 1'b1);
        chk("nv_write_busy", 32'h1, {31'h0, nv_write_busy});
        // Bounded wait; a stuck write fails the checks below
        for (n = 0; n < 50 && nv_write_busy; n++) begin
            @(posedge clk);
            #1;
        end
        chk("nv_write_busy", 32'h0, {31'h0, nv_write_busy});
        // Wait starts one cycle into the write, so NVC - 1 remain
        chk("nv_write_cycles", NVC - 1, n);
        r(8'h03, 32'h0064_000a);
        // Delta mode: nothing before reference, then differences
        w(8'h03, 32'h0084_000a, 1'b1);
        smp(12'h014, 12'h0, 12'h0, 1'b0);
        @(posedge clk);
        duty_cycle_pin <= 1'b1;
        repeat (4) @(posedge clk);
        smp(12'h014, 12'h0, 12'h0, 1'b0);
        smp(12'h019, 12'h0, 12'h0, 1'b0);
        smp(12'h023, 12'h0, 12'h0, 1'b1);
        smp(12'h00a, 12'h0, 12'h0, 1'b1);
        wrap_up();
    end
endmodule : fte_event_core_tb_top
